// [pkg/vdpa_params.svh]
// timing, count and width constants of the dual-port vram arbiter
//
// Behaviour
// - staggered refresh plus scrubbing selects test mode
// - test mode splits counter 13/11, both increment
// - row hold 15 or 25 ns by select
// - column setup 0 or 10 ns by select
// - delay clock paces delay line and refresh
// - works with related or unrelated delay clock
// - row hold scales with delay clock ratio
// - column setup scales with delay clock ratio
// - column strobe delay shifts with both errors
// - refresh first, granted port, then ungranted port
// - grant stays until ungranted port requests
// - port b row strobe follows its request
// - column strobes may outlast row strobe if enabled
// - ungranted port b starts one/two edges after grant
// - grant to b only when a idle, unlocked
// - grant changes after request ends, leads row strobe
// - port b ack from row strobe to request end
// - lock holds other port out with waits
// - grant high for port b, low for a
// - row timing bit 0 picks first/second edge
// - column strobe needs selection and enable
`ifndef VDPA_PARAMS_SVH
`define VDPA_PARAMS_SVH

`define VDPA_CLK_PERIOD_NS    10
`define VDPA_REF_PERIOD_NS    500
`define VDPA_RAH_SHORT_NS     15
`define VDPA_RAH_LONG_NS      25
`define VDPA_RAH_SCALE_NS     30
`define VDPA_ASC_SHORT_NS     0
`define VDPA_ASC_LONG_NS      10
`define VDPA_ASC_SCALE_SHORT  15
`define VDPA_ASC_SCALE_LONG   25
`define VDPA_ASC_OFFSET_NS    15
`define VDPA_REF_CNT_W        24
`define VDPA_REF_LO_W         13
`define VDPA_REF_HI_W         11
`define VDPA_RESET_GRANT      1'h0
`define VDPA_RESET_CNT        24'h000000

`endif

// [pkg/vdpa_pkg.sv]
// types shared by the dual-port vram arbiter
`default_nettype none
package vdpa_pkg;

    typedef struct packed {
        logic [1:0] row_timing_bits;
        logic       row_hold_select_bit;
        logic       column_setup_select_bit;
        logic       staggered_refresh;
        logic       error_scrub;
        logic       column_enable_hold;
    } vdpa_prog_t;

    typedef struct packed {
        logic       chip_select_n;
        logic       address_strobe_latch;
        logic       port_a_access_request_n;
    } vdpa_port_a_t;

    typedef enum logic [2:0] {
        ARB_IDLE       = 3'h0,
        ARB_GRANT_WAIT = 3'h1,
        ARB_ACCESS     = 3'h2,
        ARB_PRECHARGE  = 3'h3,
        ARB_REFRESH    = 3'h4
    } vdpa_arb_state_t;

    typedef enum logic [1:0] {
        DLY_IDLE = 2'h0,
        DLY_ROW  = 2'h1,
        DLY_COL  = 2'h2,
        DLY_DONE = 2'h3
    } vdpa_dly_state_t;

endpackage : vdpa_pkg
`default_nettype wire

// [src/vdpa_refresh_ctr.sv]
// refresh address counter with split test mode
`include "vdpa_params.svh"
`default_nettype none
module vdpa_refresh_ctr (
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        test_mode_i,
    input  wire logic                        inc_i,
    output var  logic [`VDPA_REF_CNT_W-1:0]  count_o
);
    import vdpa_pkg::*;

    logic [`VDPA_REF_CNT_W-1:0] cnt_q;
    logic [`VDPA_REF_CNT_W-1:0] cnt_d;

    // =====================================================
    // next count
    always_comb begin
        cnt_d = cnt_q;
        if (inc_i) begin
            if (test_mode_i) begin
                // both halves step together
                cnt_d[`VDPA_REF_LO_W-1:0] = cnt_q[`VDPA_REF_LO_W-1:0] + 13'h0001;
                cnt_d[`VDPA_REF_CNT_W-1:`VDPA_REF_LO_W] =
                    cnt_q[`VDPA_REF_CNT_W-1:`VDPA_REF_LO_W] + 11'h001;
            end else begin
                cnt_d = cnt_q + 24'h000001;
            end
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= `VDPA_RESET_CNT;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;

endmodule : vdpa_refresh_ctr
`default_nettype wire

// [src/vdpa_delay_timer.sv]
// row hold and column setup delay line, scaled by delay clock period
`include "vdpa_params.svh"
`default_nettype none
module vdpa_delay_timer (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       start_i,
    input  wire logic       stop_i,
    input  wire logic       rah_long_i,
    input  wire logic       asc_long_i,
    input  wire logic [3:0] divisor_i,
    input  wire logic [7:0] period_i,
    output var  logic       col_sel_o,
    output var  logic       cas_go_o
);
    import vdpa_pkg::*;

    vdpa_dly_state_t st_q;
    vdpa_dly_state_t st_d;
    logic [7:0]      cnt_q;
    logic [7:0]      cnt_d;
    logic            col_q;
    logic            col_d;
    logic            go_q;
    logic            go_d;
    int              ratio_x;
    int              rah_ns;
    int              asc_ns;
    logic [7:0]      rah_cyc;
    logic [7:0]      asc_cyc;

    // least time, rounded up, never below one cycle
    function automatic logic [7:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + `VDPA_CLK_PERIOD_NS - 1) / `VDPA_CLK_PERIOD_NS;
        if (c < 1) c = 1;
        if (c > 255) c = 255;
        return c[7:0];
    endfunction : ns_to_cyc

    // =====================================================
    // actual times from divisor * 2 MHz / delay clock frequency
    always_comb begin
        ratio_x = int'(divisor_i) * int'(period_i) * `VDPA_CLK_PERIOD_NS;
        rah_ns  = rah_long_i ? `VDPA_RAH_LONG_NS : `VDPA_RAH_SHORT_NS;
        asc_ns  = asc_long_i ? `VDPA_ASC_LONG_NS : `VDPA_ASC_SHORT_NS;
        if (period_i != 8'h00) begin
            rah_ns = (`VDPA_RAH_SCALE_NS * ratio_x) / `VDPA_REF_PERIOD_NS
                     - `VDPA_RAH_SCALE_NS + rah_ns;
            asc_ns = ((asc_long_i ? `VDPA_ASC_SCALE_LONG : `VDPA_ASC_SCALE_SHORT) * ratio_x)
                     / `VDPA_REF_PERIOD_NS - `VDPA_ASC_OFFSET_NS;
        end
        rah_cyc = ns_to_cyc(rah_ns);
        asc_cyc = ns_to_cyc(asc_ns);
    end

    // =====================================================
    // sequence: row hold, then column setup, then strobe
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        col_d = col_q;
        go_d  = go_q;
        case (st_q)
            DLY_IDLE: begin
                if (start_i) begin
                    st_d  = DLY_ROW;
                    cnt_d = rah_cyc;
                end
            end
            DLY_ROW: begin
                if (cnt_q <= 8'h01) begin
                    st_d  = DLY_COL;
                    col_d = 1'b1;
                    cnt_d = asc_cyc;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            DLY_COL: begin
                // strobe delay shifts by both time errors
                if (cnt_q <= 8'h01) begin
                    st_d = DLY_DONE;
                    go_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            DLY_DONE: begin
            end
            default: begin
                st_d = DLY_IDLE;
            end
        endcase
        if (stop_i) begin
            st_d  = DLY_IDLE;
            col_d = 1'b0;
            go_d  = 1'b0;
            cnt_d = 8'h00;
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_q  <= DLY_IDLE;
            cnt_q <= 8'h00;
            col_q <= 1'b0;
            go_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            col_q <= col_d;
            go_q  <= go_d;
        end
    end

    assign col_sel_o = col_q;
    assign cas_go_o  = go_q;

endmodule : vdpa_delay_timer
`default_nettype wire

// [src/vdpa_arbiter.sv]
// dual-port vram arbiter with refresh, grant, lock and strobe timing
`include "vdpa_params.svh"
`default_nettype none
module vdpa_arbiter #(
    parameter int unsigned REFRESH_INTERVAL = 30
) (
    input  wire logic                        CLK_I,
    input  wire logic                        RESET_N_I,
    input  wire logic                        PROGRAM_I,
    input  wire vdpa_pkg::vdpa_prog_t        PROG_CFG_I,
    input  wire logic [3:0]                  DELAY_DIVISOR_I,
    input  wire logic                        DELAY_LINE_CLOCK_I,
    input  wire vdpa_pkg::vdpa_port_a_t      PORT_A_I,
    input  wire logic                        PORT_B_ACCESS_REQUEST_N_I,
    input  wire logic                        LOCK_N_I,
    input  wire logic [1:0]                  COLUMN_ENABLE_INPUTS_N_I,
    input  wire logic [1:0]                  BANK_SELECT_INPUTS_I,
    output var  logic                        PORT_B_GRANT_O,
    output var  logic                        PORT_B_ADVANCE_ACK_N_O,
    output var  logic                        PORT_A_WAIT_O,
    output var  logic [3:0]                  RAS_N_O,
    output var  logic [3:0]                  CAS_N_O,
    output var  logic                        COLUMN_ADDRESS_SELECT_O,
    output var  logic                        TEST_MODE_O,
    output var  logic [`VDPA_REF_CNT_W-1:0]  REFRESH_COUNT_O
);
    import vdpa_pkg::*;

    // =====================================================
    // declarations
    vdpa_prog_t      prog_q;
    vdpa_prog_t      prog_d;
    logic            test_q;
    logic            test_d;
    vdpa_arb_state_t st_q;
    vdpa_arb_state_t st_d;
    logic [2:0]      cnt_q;
    logic [2:0]      cnt_d;
    logic            grant_q;
    logic            grant_d;
    logic            ack_n_q;
    logic            ack_n_d;
    logic            wait_q;
    logic            wait_d;
    logic [3:0]      ras_n_q;
    logic [3:0]      ras_n_d;
    logic [3:0]      cas_n_q;
    logic [3:0]      cas_n_d;
    logic            dsync1_q;
    logic            dsync2_q;
    logic            dsync3_q;
    logic            dlvl_q;
    logic            dlvl_d;
    logic            drise;
    logic [7:0]      per_cnt_q;
    logic [7:0]      per_cnt_d;
    logic [7:0]      per_q;
    logic [7:0]      per_d;
    logic [11:0]     ref_div_q;
    logic [11:0]     ref_div_d;
    logic            ref_tick;
    logic            ref_pend_q;
    logic            ref_pend_d;
    logic            ref_take;
    logic            dly_start;
    logic            dly_stop;
    logic            col_sel;
    logic            cas_go;
    logic            a_req;
    logic            b_req;
    logic            cur_req;
    logic            oth_req;
    logic            locked;
    logic [3:0]      cas_en;
    logic [3:0]      bank_ras;
    logic [2:0]      ref_low;
    logic [2:0]      pre_len;

    // =====================================================
    // programming capture
    always_comb begin
        prog_d = PROGRAM_I ? PROG_CFG_I : prog_q;
        test_d = prog_d.staggered_refresh & prog_d.error_scrub;
    end

    // =====================================================
    // delay line clock: three flops, change counts when 2nd and 3rd agree
    always_comb begin
        dlvl_d    = (dsync2_q == dsync3_q) ? dsync3_q : dlvl_q;
        drise     = dlvl_d & ~dlvl_q;
        per_cnt_d = (per_cnt_q == 8'hFF) ? per_cnt_q : per_cnt_q + 8'h01;
        per_d     = per_q;
        if (drise) begin
            per_d     = per_cnt_q;
            per_cnt_d = 8'h01;
        end
        // refresh request clock runs from the delay clock
        ref_div_d = ref_div_q;
        ref_tick  = 1'b0;
        if (drise) begin
            if (ref_div_q >= 12'(REFRESH_INTERVAL - 1)) begin
                ref_div_d = 12'h000;
                ref_tick  = 1'b1;
            end else begin
                ref_div_d = ref_div_q + 12'h001;
            end
        end
        // a new request wins over the take in the same cycle
        ref_pend_d = ref_tick | (ref_pend_q & ~ref_take);
    end

    // =====================================================
    // request decode and timing selects
    always_comb begin
        a_req   = ~PORT_A_I.chip_select_n &
                  (PORT_A_I.address_strobe_latch | ~PORT_A_I.port_a_access_request_n);
        b_req   = ~PORT_B_ACCESS_REQUEST_N_I;
        locked  = ~LOCK_N_I;
        cur_req = grant_q ? b_req : a_req;
        oth_req = grant_q ? a_req : b_req;
        cas_en  = {~{2{COLUMN_ENABLE_INPUTS_N_I[1]}}, ~{2{COLUMN_ENABLE_INPUTS_N_I[0]}}};
        bank_ras = ~(4'h1 << BANK_SELECT_INPUTS_I);
        case (prog_q.row_timing_bits)
            2'h0: begin
                ref_low = 3'h2;
                pre_len = 3'h1;
            end
            2'h1: begin
                ref_low = 3'h3;
                pre_len = 3'h2;
            end
            2'h2: begin
                ref_low = 3'h2;
                pre_len = 3'h2;
            end
            default: begin
                ref_low = 3'h4;
                pre_len = 3'h3;
            end
        endcase
    end

    // =====================================================
    // arbitration and strobe state machine
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        grant_d   = grant_q;
        ack_n_d   = ack_n_q;
        ras_n_d   = ras_n_q;
        ref_take  = 1'b0;
        dly_start = 1'b0;
        dly_stop  = 1'b0;
        case (st_q)
            ARB_IDLE: begin
                if (ref_pend_q) begin
                    st_d     = ARB_REFRESH;
                    ras_n_d  = 4'h0;
                    cnt_d    = ref_low - 3'h1;
                    ref_take = 1'b1;
                end else if (!cur_req && oth_req && !locked) begin
                    // switch only once the owner is idle and unlocked
                    grant_d = ~grant_q;
                    st_d    = ARB_GRANT_WAIT;
                    cnt_d   = prog_q.row_timing_bits[0] ? 3'h1 : 3'h0;
                end else if (cur_req) begin
                    st_d      = ARB_ACCESS;
                    ras_n_d   = bank_ras;
                    dly_start = 1'b1;
                    ack_n_d   = ~grant_q;
                end
            end
            ARB_GRANT_WAIT: begin
                if (cnt_q != 3'h0) begin
                    cnt_d = cnt_q - 3'h1;
                end else if (ref_pend_q) begin
                    st_d = ARB_IDLE;
                end else if (cur_req) begin
                    st_d      = ARB_ACCESS;
                    ras_n_d   = bank_ras;
                    dly_start = 1'b1;
                    ack_n_d   = ~grant_q;
                end else begin
                    st_d = ARB_IDLE;
                end
            end
            ARB_ACCESS: begin
                if (!cur_req) begin
                    st_d     = ARB_PRECHARGE;
                    ras_n_d  = 4'hF;
                    ack_n_d  = 1'b1;
                    dly_stop = 1'b1;
                    cnt_d    = pre_len - 3'h1;
                end
            end
            ARB_REFRESH: begin
                if (cnt_q == 3'h0) begin
                    st_d    = ARB_PRECHARGE;
                    ras_n_d = 4'hF;
                    cnt_d   = pre_len - 3'h1;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ARB_PRECHARGE: begin
                if (cnt_q == 3'h0) begin
                    st_d = ARB_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: begin
                st_d    = ARB_IDLE;
                ras_n_d = 4'hF;
                ack_n_d = 1'b1;
            end
        endcase
    end

    // =====================================================
    // column strobes and port a wait
    always_comb begin
        cas_n_d = 4'hF;
        if (st_q == ARB_ACCESS && cur_req && cas_go) begin
            cas_n_d = ~cas_en;
        end else if (prog_q.column_enable_hold) begin
            cas_n_d = cas_n_q | ~cas_en;
        end
        // port a waits unless its own access runs
        wait_d = a_req & ~(st_q == ARB_ACCESS && !grant_q);
    end

    // =====================================================
    // registers
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            prog_q     <= '0;
            test_q     <= 1'b0;
            st_q       <= ARB_IDLE;
            cnt_q      <= 3'h0;
            grant_q    <= `VDPA_RESET_GRANT;
            ack_n_q    <= 1'b1;
            wait_q     <= 1'b0;
            ras_n_q    <= 4'hF;
            cas_n_q    <= 4'hF;
            dsync1_q   <= 1'b0;
            dsync2_q   <= 1'b0;
            dsync3_q   <= 1'b0;
            dlvl_q     <= 1'b0;
            per_cnt_q  <= 8'h00;
            per_q      <= 8'h00;
            ref_div_q  <= 12'h000;
            ref_pend_q <= 1'b0;
        end else begin
            prog_q     <= prog_d;
            test_q     <= test_d;
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            grant_q    <= grant_d;
            ack_n_q    <= ack_n_d;
            wait_q     <= wait_d;
            ras_n_q    <= ras_n_d;
            cas_n_q    <= cas_n_d;
            dsync1_q   <= DELAY_LINE_CLOCK_I;
            dsync2_q   <= dsync1_q;
            dsync3_q   <= dsync2_q;
            dlvl_q     <= dlvl_d;
            per_cnt_q  <= per_cnt_d;
            per_q      <= per_d;
            ref_div_q  <= ref_div_d;
            ref_pend_q <= ref_pend_d;
        end
    end

    // =====================================================
    // submodules
    vdpa_delay_timer u_delay (
        .clk_i      (CLK_I),
        .reset_n_i  (RESET_N_I),
        .start_i    (dly_start),
        .stop_i     (dly_stop),
        .rah_long_i (prog_q.row_hold_select_bit),
        .asc_long_i (prog_q.column_setup_select_bit),
        .divisor_i  (DELAY_DIVISOR_I),
        .period_i   (per_q),
        .col_sel_o  (col_sel),
        .cas_go_o   (cas_go)
    );

    vdpa_refresh_ctr u_refresh (
        .clk_i       (CLK_I),
        .reset_n_i   (RESET_N_I),
        .test_mode_i (test_q),
        .inc_i       (ref_take),
        .count_o     (REFRESH_COUNT_O)
    );

    // =====================================================
    // outputs
    assign PORT_B_GRANT_O          = grant_q;
    assign PORT_B_ADVANCE_ACK_N_O  = ack_n_q;
    assign PORT_A_WAIT_O           = wait_q;
    assign RAS_N_O                 = ras_n_q;
    assign CAS_N_O                 = cas_n_q;
    assign COLUMN_ADDRESS_SELECT_O = col_sel;
    assign TEST_MODE_O             = test_q;

endmodule : vdpa_arbiter
`default_nettype wire

// [verif/vdpa_pb_cpu.sv]
// port b cpu model: holds its request until acknowledged, then for a set time
`default_nettype none
module vdpa_pb_cpu (
    input  wire logic clk_i,
    input  wire logic ack_n_i,
    output var  logic req_n_o,
    output var  logic tmo_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_n_o = 1'b1;
        tmo_o = 1'b0;
    end
    task automatic access(input int hold);
        int n = 0;
        @(posedge clk_i);
        req_n_o <= 1'b0;
        @(posedge clk_i);
        while (ack_n_i !== 1'b0 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 60) tmo_o <= 1'b1;
        repeat (hold) @(posedge clk_i);
        req_n_o <= 1'b1;
    endtask : access
endmodule : vdpa_pb_cpu
`default_nettype wire

// [verif/vdpa_arbiter_chk.sv]
// port checker for the dual-port vram arbiter
`include "vdpa_params.svh"
`default_nettype none
module vdpa_arbiter_chk #(
    parameter int unsigned REFRESH_INTERVAL = 30
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic PROGRAM_I,
    input wire vdpa_pkg::vdpa_prog_t PROG_CFG_I,
    input wire logic [3:0] DELAY_DIVISOR_I,
    input wire logic DELAY_LINE_CLOCK_I,
    input wire vdpa_pkg::vdpa_port_a_t PORT_A_I,
    input wire logic PORT_B_ACCESS_REQUEST_N_I,
    input wire logic LOCK_N_I,
    input wire logic [1:0] COLUMN_ENABLE_INPUTS_N_I,
    input wire logic [1:0] BANK_SELECT_INPUTS_I,
    input wire logic PORT_B_GRANT_O,
    input wire logic PORT_B_ADVANCE_ACK_N_O,
    input wire logic PORT_A_WAIT_O,
    input wire logic [3:0] RAS_N_O,
    input wire logic [3:0] CAS_N_O,
    input wire logic COLUMN_ADDRESS_SELECT_O,
    input wire logic TEST_MODE_O,
    input wire logic [`VDPA_REF_CNT_W-1:0] REFRESH_COUNT_O
);
    timeunit 1ns;
    timeprecision 1ns;
    import vdpa_pkg::*;
    logic g_b, ack_n, req_n, ras_idle, a_req, tm_in, b0_d, b0_q;
    logic [12:0] cnt_lo;
    logic [10:0] cnt_hi;
    assign g_b = PORT_B_GRANT_O;
    assign ack_n = PORT_B_ADVANCE_ACK_N_O;
    assign req_n = PORT_B_ACCESS_REQUEST_N_I;
    assign ras_idle = RAS_N_O == 4'hF;
    assign cnt_lo = REFRESH_COUNT_O[12:0];
    assign cnt_hi = REFRESH_COUNT_O[23:13];
    assign a_req = !PORT_A_I.chip_select_n
        && (PORT_A_I.address_strobe_latch || !PORT_A_I.port_a_access_request_n);
    assign tm_in = PROG_CFG_I.staggered_refresh && PROG_CFG_I.error_scrub;
    always_comb b0_d = PROGRAM_I ? PROG_CFG_I.row_timing_bits[0] : b0_q;
    always_ff @(posedge CLK_I) b0_q <= RESET_N_I ? b0_d : 1'b0;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    property p_grant_rst;
        $rose(RESET_N_I) |-> !g_b;
    endproperty
    a_grant_rst: assert property (p_grant_rst) else $error("grant set after reset");
    property p_test_mode;
        PROGRAM_I ##1 !PROGRAM_I |=> TEST_MODE_O == $past(tm_in, 2);
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("test mode wrong");
    property p_split_cnt;
        TEST_MODE_O && $changed(REFRESH_COUNT_O) |->
            cnt_lo == 13'($past(cnt_lo) + 13'h1) && cnt_hi == 11'($past(cnt_hi) + 11'h1);
    endproperty
    a_split_cnt: assert property (p_split_cnt) else $error("split count wrong");
    property p_grant_b;
        $rose(g_b) |-> !$past(req_n) && $past(LOCK_N_I) && !$past(a_req);
    endproperty
    a_grant_b: assert property (p_grant_b) else $error("grant to b unasked");
    property p_lock;
        !LOCK_N_I |=> $stable(g_b);
    endproperty
    a_lock: assert property (p_lock) else $error("grant moved under lock");
    property p_ras_lead;
        $rose(g_b) |-> ras_idle ##1 (ras_idle == b0_q) ##1 !ras_idle;
    endproperty
    a_ras_lead: assert property (p_ras_lead) else $error("row strobe edge wrong");
    property p_ack_ras;
        $fell(ack_n) |-> !ras_idle && g_b;
    endproperty
    a_ack_ras: assert property (p_ack_ras) else $error("ack without row strobe");
    property p_ack_end;
        !ack_n && req_n |=> ack_n && ras_idle;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack or strobe stuck");
    c_grant_b: cover property ($rose(g_b));
    c_lock: cover property (!LOCK_N_I && !req_n);
    c_refresh: cover property (TEST_MODE_O && $changed(REFRESH_COUNT_O));
endmodule : vdpa_arbiter_chk
bind vdpa_arbiter vdpa_arbiter_chk #(.REFRESH_INTERVAL(REFRESH_INTERVAL))
    u_vdpa_arbiter_chk (.CLK_I, .RESET_N_I, .PROGRAM_I, .PROG_CFG_I, .DELAY_DIVISOR_I,
    .DELAY_LINE_CLOCK_I, .PORT_A_I, .PORT_B_ACCESS_REQUEST_N_I, .LOCK_N_I,
    .COLUMN_ENABLE_INPUTS_N_I, .BANK_SELECT_INPUTS_I, .PORT_B_GRANT_O,
    .PORT_B_ADVANCE_ACK_N_O, .PORT_A_WAIT_O, .RAS_N_O, .CAS_N_O,
    .COLUMN_ADDRESS_SELECT_O, .TEST_MODE_O, .REFRESH_COUNT_O);
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the dual-port vram arbiter
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import vdpa_pkg::*;
    logic CLK_I, RESET_N_I, PROGRAM_I, DELAY_LINE_CLOCK_I, LOCK_N_I;
    logic PORT_B_ACCESS_REQUEST_N_I, PORT_B_GRANT_O, PORT_B_ADVANCE_ACK_N_O;
    logic TEST_MODE_O, dly_en, dly_ph, tmo, PORT_A_WAIT_O, COLUMN_ADDRESS_SELECT_O;
    logic [3:0] RAS_N_O, CAS_N_O, DELAY_DIVISOR_I;
    logic [1:0] BANK_SELECT_INPUTS_I, COLUMN_ENABLE_INPUTS_N_I;
    logic [23:0] REFRESH_COUNT_O;
    vdpa_prog_t PROG_CFG_I;
    vdpa_port_a_t PORT_A_I;
    int error_cnt = 0;
    int cmp_count = 0;
    vdpa_arbiter #(.REFRESH_INTERVAL(4)) u_vdpa_arbiter (
        .CLK_I, .RESET_N_I, .PROGRAM_I, .PROG_CFG_I, .DELAY_DIVISOR_I, .DELAY_LINE_CLOCK_I,
        .PORT_A_I, .PORT_B_ACCESS_REQUEST_N_I, .LOCK_N_I, .COLUMN_ENABLE_INPUTS_N_I,
        .BANK_SELECT_INPUTS_I, .PORT_B_GRANT_O, .PORT_B_ADVANCE_ACK_N_O, .PORT_A_WAIT_O,
        .RAS_N_O, .CAS_N_O, .COLUMN_ADDRESS_SELECT_O, .TEST_MODE_O, .REFRESH_COUNT_O);
    vdpa_pb_cpu u_vdpa_pb_cpu (.clk_i(CLK_I), .ack_n_i(PORT_B_ADVANCE_ACK_N_O),
        .req_n_o(PORT_B_ACCESS_REQUEST_N_I), .tmo_o(tmo));
    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        if (dly_en) dly_ph <= ~dly_ph;
        if (dly_en && dly_ph) DELAY_LINE_CLOCK_I <= ~DELAY_LINE_CLOCK_I;
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask : cyc
    task automatic wt(input int sel, input logic [23:0] v);
        logic [23:0] s;
        repeat (60) begin
            cyc(1);
            s = sel == 0 ? 24'(PORT_B_GRANT_O)
                : sel == 1 ? 24'(PORT_B_ADVANCE_ACK_N_O) : REFRESH_COUNT_O;
            if (s === v) return;
        end
        chk("wait", s, v);
        end_sim();
    endtask : wt
    task automatic prog_cfg(input logic [6:0] c);
        @(posedge CLK_I);
        PROG_CFG_I <= c;
        PROGRAM_I <= 1'b1;
        @(posedge CLK_I);
        PROGRAM_I <= 1'b0;
        cyc(1);
    endtask : prog_cfg
    task automatic take_a();
        @(posedge CLK_I);
        PORT_A_I <= 3'h3;
        wt(0, 24'h0);
        chk("wait", 24'(PORT_A_WAIT_O), 24'h1);
        @(posedge CLK_I);
        PORT_A_I <= 3'h5;
    endtask : take_a
    initial begin
        RESET_N_I = 1'b0;
        PROGRAM_I = 1'b0;
        PROG_CFG_I = '0;
        DELAY_DIVISOR_I = 4'h0;
        DELAY_LINE_CLOCK_I = 1'b0;
        dly_ph = 1'b0;
        dly_en = 1'b0;
        PORT_A_I = 3'h5;
        LOCK_N_I = 1'b1;
        COLUMN_ENABLE_INPUTS_N_I = 2'h0;
        BANK_SELECT_INPUTS_I = 2'h2;
        repeat (3) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        cyc(1);
        chk("grant", 24'(PORT_B_GRANT_O), 24'h0);
        prog_cfg(7'h01);
        chk("test", 24'(TEST_MODE_O), 24'h0);
        fork
            u_vdpa_pb_cpu.access(4);
            begin
                wt(1, 24'h0);
                chk("ras", 24'(RAS_N_O), 24'h00000B);
                chk("grant", 24'(PORT_B_GRANT_O), 24'h1);
                cyc(2);
                chk("col", 24'(COLUMN_ADDRESS_SELECT_O), 24'h1);
                cyc(2);
                chk("cas", 24'(CAS_N_O), 24'h0);
            end
        join
        cyc(2);
        chk("ras", 24'(RAS_N_O), 24'h00000F);
        chk("ack", 24'(PORT_B_ADVANCE_ACK_N_O), 24'h1);
        chk("grant", 24'(PORT_B_GRANT_O), 24'h1);
        chk("cas", 24'(CAS_N_O), 24'h0);
        take_a();
        @(posedge CLK_I);
        LOCK_N_I <= 1'b0;
        fork
            u_vdpa_pb_cpu.access(2);
            begin
                cyc(10);
                chk("grant", 24'(PORT_B_GRANT_O), 24'h0);
                @(posedge CLK_I);
                LOCK_N_I <= 1'b1;
                PORT_A_I <= 3'h3;
                cyc(10);
                chk("grant", 24'(PORT_B_GRANT_O), 24'h0);
                @(posedge CLK_I);
                PORT_A_I <= 3'h5;
                wt(0, 24'h1);
            end
        join
        prog_cfg(7'h05);
        chk("test", 24'(TEST_MODE_O), 24'h0);
        prog_cfg(7'h27);
        chk("test", 24'(TEST_MODE_O), 24'h1);
        @(posedge CLK_I);
        dly_en <= 1'b1;
        wt(2, 24'h002001);
        @(posedge CLK_I);
        dly_en <= 1'b0;
        take_a();
        u_vdpa_pb_cpu.access(1);
        cyc(2);
        chk("tmo", 24'(tmo), 24'h0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
